//--- ofc_pkg.sv
// Shared constants and types for the on-chip flash port block.
package ofc_pkg;
    // Clock and timing figures.
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROGRAM_TIME_NS = 300;
    localparam int ERASE_TIME_NS = 1000;
    localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    // Control port decode and data widths.
    localparam logic CSR_STATUS_ADDR = 1'b0;
    localparam logic CSR_CONTROL_ADDR = 1'b1;
    localparam int CSR_W = 32;
    localparam int PAR_DATA_W = 32;
    localparam int SER_DATA_W = 1;
    localparam int WORD_W = 32;
    localparam int BIT_IDX_W = 5;
    localparam int SER_WORD_BITS = 32;
    localparam int BEAT_W = 13;

    // Status register layout and busy codes.
    localparam int ST_BUSY_LSB = 0;
    localparam int ST_RS_BIT = 2;
    localparam int ST_WS_BIT = 3;
    localparam int ST_ES_BIT = 4;
    localparam int ST_SP_LSB = 5;
    localparam int ST_SP_W = 5;
    localparam int ST_PAD_LSB = 10;
    localparam logic [1:0] ST_IDLE = 2'h0;
    localparam logic [1:0] ST_BUSY_ERASE = 2'h1;
    localparam logic [1:0] ST_BUSY_WRITE = 2'h2;
    localparam logic [1:0] ST_BUSY_READ = 2'h3;
    localparam logic [21:0] ST_PAD_VALUE = 22'h3fffff;

    // Control register layout and reset values.
    localparam int CT_PE_LSB = 0;
    localparam int CT_PE_W = 20;
    localparam int CT_SE_LSB = 20;
    localparam int CT_SE_W = 3;
    localparam int CT_WP_LSB = 23;
    localparam int CT_WP_W = 4;
    localparam logic [19:0] CT_PE_RST = 20'hfffff;
    localparam logic [2:0] CT_SE_RST = 3'h7;
    localparam logic [2:0] CT_SE_FIRST = 3'h1;
    localparam logic [2:0] CT_SE_LAST = 3'h5;
    localparam logic [3:0] CT_WP_RST = 4'hf;

    // Content of an erased word.
    localparam logic [31:0] FLASH_ERASED = 32'hffffffff;

    // Sequencer states.
    typedef enum logic [1:0] {S_IDLE, S_READ, S_PROGRAM, S_ERASE} ofc_state_type;
endpackage

//--- ofc_stream_if.sv
// Valid/ready word stream between the sequencer and its output buffer.
interface ofc_stream_if #(parameter int W = 32);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- ofc_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
module ofc_skid_buf #(
    parameter int W = 32
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Filling and draining sides.
    ofc_stream_if.snk in_s,
    ofc_stream_if.src out_s
);
    logic [W-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so neither side is misled.
    assign in_s.ready = (count_q != 2'h2);
    assign out_s.valid = (count_q != 2'h0);
    assign out_s.data = mem_q[rd_ptr_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_s.data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop)
            begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- ofc_flash_ports.sv
// Control and data slave ports of the on-chip user flash controller.
module ofc_flash_ports #(
    parameter bit SERIAL_MODE = 1'b0,
    parameter bit WRAP_MODE = 1'b0,
    parameter int ADDR_W = 8,
    parameter int BC_W = 4,
    parameter logic [4:0] SECTOR_PROTECT = 5'h00,
    localparam int DW = SERIAL_MODE ? ofc_pkg::SER_DATA_W : ofc_pkg::PAR_DATA_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Control port.
    input wire logic csr_addr,
    input wire logic csr_read,
    input wire logic csr_write,
    input wire logic [ofc_pkg::CSR_W-1:0] csr_writedata,
    output logic [ofc_pkg::CSR_W-1:0] csr_readdata,
    // Data port requests.
    input wire logic [ADDR_W-1:0] data_addr,
    input wire logic data_read,
    input wire logic data_write,
    input wire logic [DW-1:0] data_writedata,
    input wire logic [BC_W-1:0] data_burstcount,
    output logic data_waitrequest,
    // Data port read return.
    output logic [DW-1:0] data_readdata,
    output logic flash_port_rd_valid,
    input wire logic data_rd_ready
);
    localparam int DEPTH = 2 ** ADDR_W;

    logic rst_meta_q;
    logic rst_int_q;
    ofc_pkg::ofc_state_type state_q;
    logic [ofc_pkg::CNT_W-1:0] cnt_q;
    logic [ofc_pkg::CSR_W-1:0] csr_readdata_q;
    logic [ofc_pkg::CT_PE_W-1:0] pe_q;
    logic [ofc_pkg::CT_SE_W-1:0] se_q;
    logic [ofc_pkg::CT_WP_W-1:0] wp_q;
    logic rs_q;
    logic ws_q;
    logic es_q;
    logic erase_page_q;
    logic [ADDR_W-1:0] base_q;
    logic [ofc_pkg::BEAT_W-1:0] len_q;
    logic [ofc_pkg::BEAT_W-1:0] beat_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [ofc_pkg::WORD_W-1:0] wr_data_q;
    logic [ofc_pkg::WORD_W-1:0] ser_q;
    logic [ofc_pkg::BIT_IDX_W-1:0] ser_cnt_q;
    logic [ofc_pkg::WORD_W-1:0] flash_mem [DEPTH];
    logic [ofc_pkg::CT_PE_W-1:0] wd_pe;
    logic [ofc_pkg::CT_SE_W-1:0] wd_se;
    logic erase_req;
    logic accept_rd;
    logic accept_wr;
    logic push;
    logic last_beat;
    logic ser_last;
    logic [ADDR_W-1:0] rd_word;
    logic [ADDR_W-1:0] wrap_mask;
    logic [ofc_pkg::BIT_IDX_W-1:0] rd_bit;
    logic [ofc_pkg::WORD_W-1:0] rd_word_data;
    logic [1:0] busy_code;

    ofc_stream_if #(.W(DW)) beat_s ();
    ofc_stream_if #(.W(DW)) ret_s ();

    // Reset is taken at once but released two edges later, in step with the clock.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rst_meta_q <= 1'b1;
            rst_int_q <= 1'b1;
        end
        else
        begin
            rst_meta_q <= 1'b0;
            rst_int_q <= rst_meta_q;
        end
    end

    // Erase is requested by a control write that names a page or a sector while idle.
    assign wd_pe = csr_writedata[ofc_pkg::CT_PE_LSB +: ofc_pkg::CT_PE_W];
    assign wd_se = csr_writedata[ofc_pkg::CT_SE_LSB +: ofc_pkg::CT_SE_W];
    assign erase_req = csr_write && (csr_addr == ofc_pkg::CSR_CONTROL_ADDR)
        && (state_q == ofc_pkg::S_IDLE) && ((wd_pe != ofc_pkg::CT_PE_RST)
        || ((wd_se >= ofc_pkg::CT_SE_FIRST) && (wd_se <= ofc_pkg::CT_SE_LAST)));

    // Stall covers every busy state and a starting erase, so no request slips in beside it.
    assign data_waitrequest = (state_q != ofc_pkg::S_IDLE) || erase_req || rst_int_q;
    assign accept_rd = data_read && !data_waitrequest;
    assign accept_wr = data_write && !data_waitrequest && !data_read;
    assign ser_last = (ser_cnt_q == ofc_pkg::BIT_IDX_W'(ofc_pkg::SER_WORD_BITS - 1));

    // Beat address generation for incrementing, wrapping and serial bursts.
    always_comb
    begin
        wrap_mask = ADDR_W'(len_q - ofc_pkg::BEAT_W'(1));
        rd_bit = '0;
        if (SERIAL_MODE)
        begin
            rd_word = base_q + ADDR_W'(beat_q >> ofc_pkg::BIT_IDX_W);
            rd_bit = ofc_pkg::BIT_IDX_W'(ofc_pkg::SER_WORD_BITS - 1) - beat_q[4:0];
        end
        else if (WRAP_MODE)
        begin
            rd_word = (base_q & ~wrap_mask) | ((base_q + ADDR_W'(beat_q)) & wrap_mask);
        end
        else
        begin
            rd_word = base_q + ADDR_W'(beat_q);
        end
    end

    // Serial mode sends each word's bits most significant first.
    assign rd_word_data = flash_mem[rd_word];
    assign beat_s.valid = (state_q == ofc_pkg::S_READ);
    assign beat_s.data = SERIAL_MODE ? DW'(rd_word_data[rd_bit]) : DW'(rd_word_data);
    assign push = beat_s.valid && beat_s.ready;
    assign last_beat = (beat_q == len_q - ofc_pkg::BEAT_W'(1));

    // The buffer lets the receiver stall without losing a word.
    ofc_skid_buf #(.W(DW)) u_ret_buf (
        .sys_clk(sys_clk),
        .reset(rst_int_q),
        .in_s(beat_s),
        .out_s(ret_s)
    );
    assign ret_s.ready = data_rd_ready;
    assign flash_port_rd_valid = ret_s.valid;
    assign data_readdata = ret_s.data;

    // Sequencer: read bursts, programming and erase timing.
    always_ff @(posedge sys_clk or posedge rst_int_q)
    begin
        if (rst_int_q)
        begin
            state_q <= ofc_pkg::S_IDLE;
            cnt_q <= '0;
            base_q <= '0;
            len_q <= '0;
            beat_q <= '0;
        end
        else
        begin
            case (state_q)
                ofc_pkg::S_IDLE:
                begin
                    beat_q <= '0;
                    cnt_q <= '0;
                    if (erase_req)
                    begin
                        state_q <= ofc_pkg::S_ERASE;
                    end
                    else if (accept_rd)
                    begin
                        base_q <= data_addr;
                        len_q <= (data_burstcount == '0) ? ofc_pkg::BEAT_W'(1)
                            : ofc_pkg::BEAT_W'(data_burstcount);
                        state_q <= ofc_pkg::S_READ;
                    end
                    else if (accept_wr && (!SERIAL_MODE || ser_last))
                    begin
                        state_q <= ofc_pkg::S_PROGRAM;
                    end
                end
                ofc_pkg::S_READ:
                begin
                    if (push)
                    begin
                        beat_q <= beat_q + ofc_pkg::BEAT_W'(1);
                        if (last_beat)
                        begin
                            state_q <= ofc_pkg::S_IDLE;
                        end
                    end
                end
                ofc_pkg::S_PROGRAM:
                begin
                    cnt_q <= cnt_q + ofc_pkg::CNT_W'(1);
                    if (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::PROGRAM_CYCLES - 1))
                    begin
                        state_q <= ofc_pkg::S_IDLE;
                    end
                end
                ofc_pkg::S_ERASE:
                begin
                    cnt_q <= cnt_q + ofc_pkg::CNT_W'(1);
                    if (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::ERASE_CYCLES - 1))
                    begin
                        state_q <= ofc_pkg::S_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ofc_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Write capture; serial bits gather into a whole word before programming.
    always_ff @(posedge sys_clk or posedge rst_int_q)
    begin
        if (rst_int_q)
        begin
            wr_addr_q <= '0;
            wr_data_q <= '0;
            ser_q <= '0;
            ser_cnt_q <= '0;
        end
        else if (accept_wr)
        begin
            if (SERIAL_MODE)
            begin
                ser_q <= {ser_q[ofc_pkg::WORD_W-2:0], data_writedata[0]};
                ser_cnt_q <= ser_cnt_q + ofc_pkg::BIT_IDX_W'(1);
                wr_data_q <= {ser_q[ofc_pkg::WORD_W-2:0], data_writedata[0]};
                if (ser_cnt_q == '0)
                begin
                    wr_addr_q <= data_addr;
                end
            end
            else
            begin
                wr_addr_q <= data_addr;
                wr_data_q <= ofc_pkg::WORD_W'(data_writedata);
            end
        end
    end

    // Array: programming can only clear bits, erase sets them again.
    always_ff @(posedge sys_clk or posedge rst_int_q)
    begin
        if (rst_int_q)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                flash_mem[i] <= ofc_pkg::FLASH_ERASED;
            end
        end
        else if ((state_q == ofc_pkg::S_PROGRAM)
            && (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::PROGRAM_CYCLES - 1)))
        begin
            flash_mem[wr_addr_q] <= flash_mem[wr_addr_q] & wr_data_q;
        end
        else if ((state_q == ofc_pkg::S_ERASE)
            && (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::ERASE_CYCLES - 1)))
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (!erase_page_q || (ADDR_W'(i) == pe_q[ADDR_W-1:0]))
                begin
                    flash_mem[i] <= ofc_pkg::FLASH_ERASED;
                end
            end
        end
    end

    // Control register; erase addresses are taken only while idle, page before sector.
    always_ff @(posedge sys_clk or posedge rst_int_q)
    begin
        if (rst_int_q)
        begin
            pe_q <= ofc_pkg::CT_PE_RST;
            se_q <= ofc_pkg::CT_SE_RST;
            wp_q <= ofc_pkg::CT_WP_RST;
            erase_page_q <= 1'b0;
        end
        else
        begin
            if (csr_write && (csr_addr == ofc_pkg::CSR_CONTROL_ADDR))
            begin
                wp_q <= csr_writedata[ofc_pkg::CT_WP_LSB +: ofc_pkg::CT_WP_W];
            end
            if (erase_req)
            begin
                pe_q <= wd_pe;
                se_q <= wd_se;
                erase_page_q <= (wd_pe != ofc_pkg::CT_PE_RST);
            end
            else if ((state_q == ofc_pkg::S_ERASE)
                && (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::ERASE_CYCLES - 1)))
            begin
                pe_q <= ofc_pkg::CT_PE_RST;
                se_q <= ofc_pkg::CT_SE_RST;
            end
        end
    end

    // Result flags clear when an operation of their kind starts and set when it ends.
    always_ff @(posedge sys_clk or posedge rst_int_q)
    begin
        if (rst_int_q)
        begin
            rs_q <= 1'b0;
            ws_q <= 1'b0;
            es_q <= 1'b0;
        end
        else
        begin
            if (accept_rd)
            begin
                rs_q <= 1'b0;
            end
            else if ((state_q == ofc_pkg::S_READ) && push && last_beat)
            begin
                rs_q <= 1'b1;
            end
            if (state_q == ofc_pkg::S_PROGRAM)
            begin
                ws_q <= (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::PROGRAM_CYCLES - 1));
            end
            if (state_q == ofc_pkg::S_ERASE)
            begin
                es_q <= (cnt_q == ofc_pkg::CNT_W'(ofc_pkg::ERASE_CYCLES - 1));
            end
        end
    end

    // Busy code for the status register.
    always_comb
    begin
        case (state_q)
            ofc_pkg::S_READ: busy_code = ofc_pkg::ST_BUSY_READ;
            ofc_pkg::S_PROGRAM: busy_code = ofc_pkg::ST_BUSY_WRITE;
            ofc_pkg::S_ERASE: busy_code = ofc_pkg::ST_BUSY_ERASE;
            default: busy_code = ofc_pkg::ST_IDLE;
        endcase
    end

    // Register read answers one cycle after the strobe; status ignores writes.
    always_ff @(posedge sys_clk or posedge rst_int_q)
    begin
        if (rst_int_q)
        begin
            csr_readdata_q <= '0;
        end
        else if (csr_read)
        begin
            if (csr_addr == ofc_pkg::CSR_STATUS_ADDR)
            begin
                csr_readdata_q <= {ofc_pkg::ST_PAD_VALUE, SECTOR_PROTECT, es_q, ws_q, rs_q,
                    busy_code};
            end
            else
            begin
                csr_readdata_q <= {5'h00, wp_q, se_q, pe_q};
            end
        end
    end
    assign csr_readdata = csr_readdata_q;
endmodule

//--- ofc_flash_ports_chk.sv
// Port checker for the on-chip flash control and data ports.
module ofc_flash_ports_chk #(
    parameter int ADDR_W = 8,
    parameter int BC_W = 4,
    parameter int DW = 32,
    parameter logic [4:0] SECTOR_PROTECT = 5'h00
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Control port.
    input wire logic csr_addr,
    input wire logic csr_read,
    input wire logic csr_write,
    input wire logic [ofc_pkg::CSR_W-1:0] csr_writedata,
    input wire logic [ofc_pkg::CSR_W-1:0] csr_readdata,
    // Data port.
    input wire logic [ADDR_W-1:0] data_addr,
    input wire logic data_read,
    input wire logic data_write,
    input wire logic [DW-1:0] data_writedata,
    input wire logic [BC_W-1:0] data_burstcount,
    input wire logic data_waitrequest,
    input wire logic [DW-1:0] data_readdata,
    input wire logic flash_port_rd_valid,
    input wire logic data_rd_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [15:0] owed_q;
    logic [15:0] owed_d;
    sequence s_rd_take;
        data_read && !data_waitrequest;
    endsequence
    sequence s_wr_take;
        data_write && !data_read && !data_waitrequest;
    endsequence
    // Words owed to the master; a word shown with nothing owed is spurious.
    always_comb
    begin
        owed_d = owed_q;
        if (data_read && !data_waitrequest)
        begin
            owed_d = owed_d + ((data_burstcount == '0) ? 16'h1 : 16'(data_burstcount));
        end
        if (flash_port_rd_valid && data_rd_ready)
        begin
            owed_d = owed_d - 16'h1;
        end
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            owed_q <= 16'h0;
        end
        else
        begin
            owed_q <= owed_d;
        end
    end
    // The reset hold check runs while reset is high, so it is never disabled.
    AST_RST_HOLD: assert property (disable iff (1'b0) reset |-> data_waitrequest
        && !flash_port_rd_valid && csr_readdata == '0) else $error("outputs active in reset");
    AST_REL_SYNC: assert property ($fell(reset) |-> data_waitrequest ##[1:4] !data_waitrequest)
        else $error("reset release timing wrong");
    AST_STATUS_RD: assert property (csr_read && csr_addr == ofc_pkg::CSR_STATUS_ADDR
        |=> csr_readdata[31:5] == {22'h3fffff, SECTOR_PROTECT}) else $error("status fields wrong");
    AST_CTRL_RD: assert property (csr_read && csr_addr == ofc_pkg::CSR_CONTROL_ADDR
        |=> csr_readdata[31:27] == 5'h00) else $error("control top bits not zero");
    AST_RD_HOLD: assert property (!csr_read |=> $stable(csr_readdata))
        else $error("register output moved without a read");
    AST_WR_BUSY: assert property (s_wr_take |=> data_waitrequest [*8])
        else $error("no stall while programming");
    AST_RD_FIRST: assert property (s_rd_take |=> data_waitrequest ##[1:60] flash_port_rd_valid)
        else $error("read gave no word");
    AST_NO_SPUR: assert property (flash_port_rd_valid |-> owed_q != 16'h0)
        else $error("more words than requested");
    AST_STALL_KEEP: assert property (flash_port_rd_valid && !data_rd_ready
        |=> flash_port_rd_valid && $stable(data_readdata)) else $error("held word lost");
    AST_ERASE_BUSY: assert property (csr_write && csr_addr == ofc_pkg::CSR_CONTROL_ADDR
        && csr_writedata[19:0] != 20'hfffff && !$past(data_waitrequest) && !$past(data_read)
        && !$past(data_write) |-> data_waitrequest ##1 data_waitrequest [*8])
        else $error("no stall while erasing");
endmodule

bind ofc_flash_ports ofc_flash_ports_chk #(
    .ADDR_W(ADDR_W), .BC_W(BC_W), .DW(DW), .SECTOR_PROTECT(SECTOR_PROTECT)
) u_chk (
    .sys_clk(sys_clk), .reset(reset), .csr_addr(csr_addr), .csr_read(csr_read),
    .csr_write(csr_write), .csr_writedata(csr_writedata), .csr_readdata(csr_readdata),
    .data_addr(data_addr), .data_read(data_read), .data_write(data_write),
    .data_writedata(data_writedata), .data_burstcount(data_burstcount),
    .data_waitrequest(data_waitrequest), .data_readdata(data_readdata),
    .flash_port_rd_valid(flash_port_rd_valid), .data_rd_ready(data_rd_ready)
);

//--- ofc_master_model.sv
// Bus master model that drives the data port and collects returned words.
module ofc_master_model (
    // Clock.
    input wire logic sys_clk,
    // Requests toward the port.
    output logic [7:0] data_addr,
    output logic data_read,
    output logic data_write,
    output logic [31:0] data_writedata,
    output logic [3:0] data_burstcount,
    output logic data_rd_ready,
    // Answers from the port.
    input wire logic data_waitrequest,
    input wire logic [31:0] data_readdata,
    input wire logic flash_port_rd_valid,
    // Slow receiver mode, ready one cycle in four.
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] tick_q;
    logic [31:0] got[$];
    initial
    begin
        data_addr = 8'h00;
        data_read = 1'b0;
        data_write = 1'b0;
        data_writedata = 32'h0;
        data_burstcount = 4'h1;
        data_rd_ready = 1'b1;
        tick_q = 2'h0;
    end
    // Receiver side; stalls let the buffer fill and push back on the port.
    always @(posedge sys_clk)
    begin
        if (flash_port_rd_valid && data_rd_ready)
        begin
            got.push_back(data_readdata);
        end
        tick_q <= tick_q + 2'h1;
        data_rd_ready <= !slow || (tick_q == 2'h3);
    end
    // Holds one request until the stall drops, then drops read and write and inverts address and write data.
    task automatic req(input logic rd, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] n);
        @(posedge sys_clk);
        data_addr <= a;
        data_writedata <= d;
        data_burstcount <= n;
        data_read <= rd;
        data_write <= !rd;
        do @(posedge sys_clk); while (data_waitrequest);
        data_read <= 1'b0;
        data_write <= 1'b0;
        data_addr <= ~a;
        data_writedata <= ~d;
    endtask
endmodule

//--- ofc_flash_ports_bench.sv
// Self-checking testbench for the on-chip flash control and data ports.
`define CHK(nm, e, g) \
begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
        failures++; \
        $display("FAIL %s expected %h seen %h", nm, e, g); \
    end \
end
module ofc_flash_ports_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] SP = 5'h15;
    logic sys_clk, reset, csr_addr, csr_read, csr_write;
    logic [31:0] csr_writedata, csr_readdata, data_writedata, data_readdata;
    logic [7:0] data_addr;
    logic [3:0] data_burstcount;
    logic data_read, data_write, data_waitrequest, flash_port_rd_valid, data_rd_ready, slow;
    int failures;
    int checks_done;
    ofc_flash_ports #(.SECTOR_PROTECT(SP)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .csr_addr(csr_addr), .csr_read(csr_read),
        .csr_write(csr_write), .csr_writedata(csr_writedata), .csr_readdata(csr_readdata),
        .data_addr(data_addr), .data_read(data_read), .data_write(data_write),
        .data_writedata(data_writedata), .data_burstcount(data_burstcount),
        .data_waitrequest(data_waitrequest), .data_readdata(data_readdata),
        .flash_port_rd_valid(flash_port_rd_valid), .data_rd_ready(data_rd_ready));
    ofc_master_model u_mst (
        .sys_clk(sys_clk), .data_addr(data_addr), .data_read(data_read),
        .data_write(data_write), .data_writedata(data_writedata),
        .data_burstcount(data_burstcount), .data_rd_ready(data_rd_ready),
        .data_waitrequest(data_waitrequest), .data_readdata(data_readdata),
        .flash_port_rd_valid(flash_port_rd_valid), .slow(slow));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Register access; write data stands with the strobe for its one cycle.
    task automatic csr_wr(input logic a, input logic [31:0] d);
        @(posedge sys_clk);
        csr_addr <= a;
        csr_writedata <= d;
        csr_write <= 1'b1;
        @(posedge sys_clk);
        csr_write <= 1'b0;
    endtask
    task automatic csr_rd(input logic a, output logic [31:0] v);
        @(posedge sys_clk);
        csr_addr <= a;
        csr_read <= 1'b1;
        @(posedge sys_clk);
        csr_read <= 1'b0;
        #1 v = csr_readdata;
    endtask
    // Bounded waits; a wait that runs out shows up as a later mismatch.
    task automatic wait_idle();
        for (int n = 0; n < 500 && data_waitrequest !== 1'b0; n++) @(posedge sys_clk);
    endtask
    task automatic wait_got(input int k);
        for (int n = 0; n < 500 && u_mst.got.size() < k; n++) @(posedge sys_clk);
    endtask
    task automatic t_reset();
        repeat (16) @(posedge sys_clk);
        `CHK("stall in reset", 1'b1, data_waitrequest);
        `CHK("valid in reset", 1'b0, flash_port_rd_valid);
        `CHK("csr in reset", 32'h0, csr_readdata);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("stall after release", 1'b0, data_waitrequest);
    endtask
    task automatic t_csr();
        logic [31:0] v;
        csr_rd(1'b0, v);
        `CHK("status", {22'h3fffff, SP, 5'h00}, v);
        csr_rd(1'b1, v);
        `CHK("control", 32'h07ffffff, v);
        csr_wr(1'b0, 32'h0);
        csr_rd(1'b0, v);
        `CHK("status kept", {22'h3fffff, SP, 5'h00}, v);
        csr_wr(1'b1, 32'hfaffffff);
        csr_rd(1'b1, v);
        `CHK("control protect", 32'h02ffffff, v);
    endtask
    // Writes four words, then reads an eight-word burst and a single word behind it.
    task automatic t_rw();
        logic [31:0] v;
        logic [31:0] e;
        logic [7:0] a;
        for (int i = 3; i < 7; i++) u_mst.req(1'b0, 8'(i), 32'h5a000000 | 32'(i), 4'h1);
        csr_rd(1'b0, v);
        `CHK("busy write", ofc_pkg::ST_BUSY_WRITE, v[1:0]);
        wait_idle();
        csr_rd(1'b0, v);
        `CHK("write flag", 1'b1, v[3]);
        slow <= 1'b1;
        u_mst.req(1'b1, 8'h00, 32'h0, 4'h8);
        u_mst.req(1'b1, 8'h05, 32'h0, 4'h1);
        wait_got(9);
        `CHK("word count", 9, u_mst.got.size());
        for (int i = 0; i < 9 && i < u_mst.got.size(); i++)
        begin
            a = (i < 8) ? 8'(i) : 8'h05;
            e = (a >= 8'h03 && a <= 8'h06) ? (32'h5a000000 | 32'(a)) : 32'hffffffff;
            `CHK("read word", e, u_mst.got[i]);
        end
        slow <= 1'b0;
        u_mst.got.delete();
    endtask
    task automatic t_erase();
        logic [31:0] v;
        csr_wr(1'b1, 32'h07f00003);
        csr_rd(1'b0, v);
        `CHK("busy erase", ofc_pkg::ST_BUSY_ERASE, v[1:0]);
        wait_idle();
        csr_rd(1'b0, v);
        `CHK("erase flag", 1'b1, v[4]);
        u_mst.req(1'b1, 8'h03, 32'h0, 4'h2);
        wait_got(2);
        `CHK("erased word", 32'hffffffff, u_mst.got[0]);
        `CHK("kept word", 32'h5a000004, u_mst.got[1]);
    endtask
    initial
    begin
        #200000;
        failures++;
        close_out();
    end
    initial
    begin
        failures = 0;
        checks_done = 0;
        reset = 1'b1;
        slow = 1'b0;
        csr_addr = 1'b0;
        csr_read = 1'b0;
        csr_write = 1'b0;
        csr_writedata = 32'h0;
        t_reset();
        t_csr();
        t_rw();
        t_erase();
        close_out();
    end
endmodule
